// ===== tick_wdog_pkg.sv
// constants, field layout and carrier types for the time base and watchdog
// assumes an 8-bit register port and pin-level oscillator inputs
package tick_wdog_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [ADDR_W-1:0] TICK_CONTROL_ONE_ADDR = 8'h10;
  localparam logic [ADDR_W-1:0] TICK_CONTROL_TWO_ADDR = 8'h11;
  localparam logic [ADDR_W-1:0] MISC_CLOCK_STATUS_ADDR = 8'h3e;

  ////////////////////////////////////////////////////////////////////////////
  // tick_control_one fields
  localparam int T1_SOURCE_BIT = 7;
  localparam int T1_OTHER_HI = 3;
  localparam int T1_OTHER_LO = 0;

  // tick_control_two fields
  localparam int T2_FLAG_BIT = 7;
  localparam int T2_IEN_BIT = 6;
  localparam int T2_RATE_HI = 5;
  localparam int T2_RATE_LO = 4;
  localparam int T2_FCLR_BIT = 3;
  localparam int T2_WEN_BIT = 1;
  localparam int T2_WCLR_BIT = 0;

  // misc_clock_status fields
  localparam int MISC_MRDY_BIT = 7;
  localparam int MISC_SRDY_BIT = 6;
  localparam int MISC_SYS_HI = 3;
  localparam int MISC_SYS_LO = 2;
  localparam int MISC_MEN_BIT = 1;
  localparam int MISC_MAP_BIT = 0;

  ////////////////////////////////////////////////////////////////////////////
  // counters and reset values
  localparam int TB_W = 14;
  localparam int PRESCALE_W = 7;
  localparam int POD_W = 6;
  localparam int WDOG_W = 2;
  localparam logic [TB_W-1:0] TB_PRESET = 14'h0078;
  localparam logic [PRESCALE_W+POD_W-1:0] POD_PRESET = 13'h0078;
  localparam logic [TB_W-1:0] SUB_READY_COUNT = 14'h1f88;
  localparam logic [TB_W-1:0] SUB_READY_VALUE = TB_PRESET + SUB_READY_COUNT;
  localparam logic [WDOG_W-1:0] WDOG_LAST = 2'h3;
  localparam logic [3:0] OTHER_RESET = 4'h0;
  localparam logic [1:0] SYSCLK_RESET = 2'h0;

  typedef enum logic [1:0] {
    RATE_DIV128 = 2'b00,
    RATE_DIV4096 = 2'b01,
    RATE_DIV8192 = 2'b10,
    RATE_DIV16384 = 2'b11
  } rate_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [1:0] sysclk_sel;
    logic main_osc_enable;
    logic alt_map_select;
  } misc_ctrl_t;

  // low-bit mask whose wrap marks one period of the chosen tap
  function automatic logic [TB_W-1:0] tap_mask(input rate_t rate);
    logic [TB_W-1:0] m;
    m = 14'h3fff;
    case (rate)
      RATE_DIV128: m = 14'h007f;
      RATE_DIV4096: m = 14'h0fff;
      RATE_DIV8192: m = 14'h1fff;
      default: m = 14'h3fff;
    endcase
    return m;
  endfunction

endpackage

// ===== pin_edge_sync.sv
// two-flop synchroniser with rising-edge detect for a pin input
// assumes the pin toggles well below half the clock rate
`timescale 1ns/1ps
module pin_edge_sync (
  input wire logic clk_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  always_ff @(posedge clk_i) begin
    meta_reg <= pin_i;
    sync_reg <= meta_reg;
    last_reg <= sync_reg;
  end

  assign level_o = sync_reg;
  assign rise_o = sync_reg & ~last_reg;

endmodule

// ===== pod_counter.sv
// main-oscillator prescaler plus power-on delay counter
// assumes osc_rise_i is a one-cycle pulse per main-oscillator edge
`timescale 1ns/1ps
module pod_counter
  import tick_wdog_pkg::*;
(
  input wire logic clk_i,
  input wire logic power_on_i,
  input wire logic enable_i,
  input wire logic stop_i,
  input wire logic osc_rise_i,
  output logic div128_o,
  output logic ready_o
);

  logic [PRESCALE_W+POD_W-1:0] cnt_reg;
  logic ready_reg;
  logic run;

  // divider clock pauses in stop; with the oscillator off the counter reloads its preset
  assign run = osc_rise_i & enable_i & ~stop_i;
  assign div128_o = run & (&cnt_reg[PRESCALE_W-1:0]);

  always_ff @(posedge clk_i) begin
    if (power_on_i || !enable_i) begin
      cnt_reg <= POD_PRESET;
    end else if (run) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (power_on_i || !enable_i) begin
      ready_reg <= 1'b0;
    end else if (run && (&cnt_reg)) begin
      ready_reg <= 1'b1;
    end
  end

  assign ready_o = ready_reg;

endmodule

// ===== time_base_and_watchdog.sv
// time base, tick interrupt, watchdog and oscillator status registers
// assumes register port on clk_i; oscillator and power-on inputs are pins
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module time_base_and_watchdog
  import tick_wdog_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic power_on_i,
  input wire logic sub_osc_clk_i,
  input wire logic main_osc_clk_i,
  input wire logic stop_i,
  input wire reg_req_t req_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic tick_irq_o,
  output logic stop_wake_o,
  output logic wdog_reset_o,
  output logic periph_run_o,
  output misc_ctrl_t misc_ctrl_o,
  output logic [3:0] other_unit_sel_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic sub_rise;
  logic main_rise;
  logic power_on;

  pin_edge_sync u_sub_sync (
    .clk_i(clk_i),
    .pin_i(sub_osc_clk_i),
    .level_o(),
    .rise_o(sub_rise)
  );

  pin_edge_sync u_main_sync (
    .clk_i(clk_i),
    .pin_i(main_osc_clk_i),
    .level_o(),
    .rise_o(main_rise)
  );

  pin_edge_sync u_por_sync (
    .clk_i(clk_i),
    .pin_i(power_on_i),
    .level_o(power_on),
    .rise_o()
  );

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic tick_source_sel_reg;
  logic source_lock_reg;
  logic [3:0] other_sel_reg;
  logic tick_irq_flag_reg;
  logic tick_irq_enable_reg;
  rate_t tick_rate_reg;
  logic watchdog_enable_reg;
  logic wdog_lock_reg;
  logic [WDOG_W-1:0] wdog_div_reg;
  logic wdog_reset_reg;
  logic [1:0] sysclk_sel_reg;
  logic main_osc_enable_reg;
  logic alt_map_select_reg;
  logic sub_osc_ready_reg;
  logic [TB_W-1:0] tb_cnt_reg;
  logic [DATA_W-1:0] rdata_reg;

  logic wr_one;
  logic wr_two;
  logic wr_misc;
  logic main_div128;
  logic main_osc_ready;
  logic tb_inc;
  logic period_evt;
  logic wdog_timeout;
  logic flag_clear;
  logic wdog_clear;

  assign wr_one = req_i.wr && (req_i.addr == TICK_CONTROL_ONE_ADDR);
  assign wr_two = req_i.wr && (req_i.addr == TICK_CONTROL_TWO_ADDR);
  assign wr_misc = req_i.wr && (req_i.addr == MISC_CLOCK_STATUS_ADDR);
  assign flag_clear = wr_two && req_i.wdata[T2_FCLR_BIT];
  assign wdog_clear = wr_two && req_i.wdata[T2_WCLR_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // main oscillator prescaler and delay counter

  pod_counter u_pod (
    .clk_i(clk_i),
    .power_on_i(power_on),
    .enable_i(main_osc_enable_reg),
    .stop_i(stop_i),
    .osc_rise_i(main_rise),
    .div128_o(main_div128),
    .ready_o(main_osc_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // time base counter

  assign tb_inc = tick_source_sel_reg ? main_div128 : sub_rise;

  always_ff @(posedge clk_i) begin
    if (power_on) begin
      tb_cnt_reg <= TB_PRESET;
    end else if (tb_inc) begin
      tb_cnt_reg <= tb_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (power_on) begin
      sub_osc_ready_reg <= 1'b0;
    end else if (tb_cnt_reg == SUB_READY_VALUE) begin
      sub_osc_ready_reg <= 1'b1;
    end
  end

  assign period_evt = tb_inc && ((tb_cnt_reg & tap_mask(tick_rate_reg)) ==
                                 tap_mask(tick_rate_reg));

  ////////////////////////////////////////////////////////////////////////////
  // tick flag and interrupt

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tick_irq_flag_reg <= 1'b0;
    end else if (period_evt) begin
      tick_irq_flag_reg <= 1'b1;
    end else if (flag_clear) begin
      tick_irq_flag_reg <= 1'b0;
    end
  end

  assign tick_irq_o = tick_irq_flag_reg & tick_irq_enable_reg;

  assign stop_wake_o = tick_irq_o & ~tick_source_sel_reg;

  assign periph_run_o = ~stop_i;

  ////////////////////////////////////////////////////////////////////////////
  // watchdog

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || wdog_clear) begin
      wdog_div_reg <= '0;
    end else if (period_evt) begin
      wdog_div_reg <= wdog_div_reg + 1'b1;
    end
  end

  assign wdog_timeout = period_evt && (wdog_div_reg == WDOG_LAST) &&
                        watchdog_enable_reg && !wdog_clear;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wdog_reset_reg <= 1'b0;
    end else begin
      wdog_reset_reg <= wdog_timeout;
    end
  end

  assign wdog_reset_o = wdog_reset_reg;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || wdog_timeout) begin
      watchdog_enable_reg <= 1'b0;
    end else if (wr_two && !wdog_lock_reg) begin
      watchdog_enable_reg <= req_i.wdata[T2_WEN_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i || wdog_timeout) begin
      wdog_lock_reg <= 1'b0;
    end else if (wr_two) begin
      wdog_lock_reg <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // tick control registers

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tick_source_sel_reg <= 1'b0;
    end else if (wr_one && !source_lock_reg) begin
      tick_source_sel_reg <= req_i.wdata[T1_SOURCE_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      source_lock_reg <= 1'b0;
    end else if (wr_one) begin
      source_lock_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      other_sel_reg <= OTHER_RESET;
    end else if (wr_one) begin
      other_sel_reg <= req_i.wdata[T1_OTHER_HI:T1_OTHER_LO];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tick_irq_enable_reg <= 1'b0;
    end else if (wr_two) begin
      tick_irq_enable_reg <= req_i.wdata[T2_IEN_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tick_rate_reg <= RATE_DIV16384;
    end else if (wr_two) begin
      tick_rate_reg <= rate_t'(req_i.wdata[T2_RATE_HI:T2_RATE_LO]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // misc clock register

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sysclk_sel_reg <= SYSCLK_RESET;
    end else if (wr_misc) begin
      sysclk_sel_reg <= req_i.wdata[MISC_SYS_HI:MISC_SYS_LO];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      main_osc_enable_reg <= 1'b1;
    end else if (wr_misc) begin
      main_osc_enable_reg <= req_i.wdata[MISC_MEN_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      alt_map_select_reg <= 1'b0;
    end else if (wr_misc) begin
      alt_map_select_reg <= req_i.wdata[MISC_MAP_BIT];
    end
  end

  assign misc_ctrl_o.sysclk_sel = sysclk_sel_reg;
  assign misc_ctrl_o.main_osc_enable = main_osc_enable_reg;
  assign misc_ctrl_o.alt_map_select = alt_map_select_reg;
  assign other_unit_sel_o = other_sel_reg;

  ////////////////////////////////////////////////////////////////////////////
  // read path, data one cycle after the strobe

  logic [DATA_W-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    case (req_i.addr)
      TICK_CONTROL_ONE_ADDR: begin
        rd_mux[T1_SOURCE_BIT] = tick_source_sel_reg;
        rd_mux[T1_OTHER_HI:T1_OTHER_LO] = other_sel_reg;
      end
      TICK_CONTROL_TWO_ADDR: begin
        rd_mux[T2_FLAG_BIT] = tick_irq_flag_reg;
        rd_mux[T2_IEN_BIT] = tick_irq_enable_reg;
        rd_mux[T2_RATE_HI:T2_RATE_LO] = tick_rate_reg;
        rd_mux[T2_WEN_BIT] = watchdog_enable_reg;
      end
      MISC_CLOCK_STATUS_ADDR: begin
        rd_mux[MISC_MRDY_BIT] = main_osc_ready;
        rd_mux[MISC_SRDY_BIT] = sub_osc_ready_reg;
        rd_mux[MISC_SYS_HI:MISC_SYS_LO] = sysclk_sel_reg;
        rd_mux[MISC_MEN_BIT] = main_osc_enable_reg;
        rd_mux[MISC_MAP_BIT] = alt_map_select_reg;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_reg <= '0;
    end else if (req_i.rd) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= '0;
    end
  end

  assign rdata_o = rdata_reg;

endmodule

// ===== time_base_and_watchdog_props.sv
// port-level assertions for the time base and watchdog block
// assumes one clock domain and the synchronous active-low reset
`timescale 1ns/1ps
module time_base_and_watchdog_props
  import tick_wdog_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic power_on_i,
  input wire logic sub_osc_clk_i,
  input wire logic main_osc_clk_i,
  input wire logic stop_i,
  input wire reg_req_t req_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic tick_irq_o,
  input wire logic stop_wake_o,
  input wire logic wdog_reset_o,
  input wire logic periph_run_o,
  input wire misc_ctrl_t misc_ctrl_o,
  input wire logic [3:0] other_unit_sel_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  property p_one_read;
    $past(req_i.rd) && $past(req_i.addr) == TICK_CONTROL_ONE_ADDR
      |-> rdata_o[6:4] == 3'h0 && rdata_o[3:0] == other_unit_sel_o;
  endproperty
  a_one_read: assert property (p_one_read) else $error("control one readback wrong");
  property p_two_read;
    $past(req_i.rd) && $past(req_i.addr) == TICK_CONTROL_TWO_ADDR
      |-> rdata_o[3] == 1'b0 && rdata_o[2] == 1'b0 && rdata_o[0] == 1'b0;
  endproperty
  a_two_read: assert property (p_two_read) else $error("control two spare bits set");
  property p_misc_read;
    $past(req_i.rd) && $past(req_i.addr) == MISC_CLOCK_STATUS_ADDR
      |-> rdata_o[5:4] == 2'h0 && rdata_o[3:0] == misc_ctrl_o;
  endproperty
  a_misc_read: assert property (p_misc_read) else $error("misc readback wrong");
  property p_irq_rdata;
    $past(req_i.rd) && $past(req_i.addr) == TICK_CONTROL_TWO_ADDR
      |-> $past(tick_irq_o) == (rdata_o[7] && rdata_o[6]);
  endproperty
  a_irq_rdata: assert property (p_irq_rdata) else $error("irq not flag and enable");
  property p_irq_clear;
    $fell(tick_irq_o) |-> !$past(rst_n_i) ||
      ($past(req_i.wr) && $past(req_i.addr) == TICK_CONTROL_TWO_ADDR);
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq dropped without write");
  property p_wake;
    stop_wake_o |-> tick_irq_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake without tick irq");
  property p_run;
    periph_run_o == !stop_i;
  endproperty
  a_run: assert property (p_run) else $error("peripheral run wrong");
  property p_wdog_once;
    wdog_reset_o |=> !wdog_reset_o [*8];
  endproperty
  a_wdog_once: assert property (p_wdog_once) else $error("watchdog reset repeated");
  property p_wdog_clear;
    req_i.wr && req_i.addr == TICK_CONTROL_TWO_ADDR && req_i.wdata[T2_WCLR_BIT]
      |=> !wdog_reset_o;
  endproperty
  a_wdog_clear: assert property (p_wdog_clear) else $error("reset despite clear");
  property p_reset_state;
    $rose(rst_n_i) |-> misc_ctrl_o == 4'h2 && other_unit_sel_o == 4'h0 && !tick_irq_o;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset values wrong");
  c_wdog: cover property (wdog_reset_o);
  c_wake: cover property (stop_wake_o);
  c_irq_clear: cover property ($fell(tick_irq_o));
endmodule

bind time_base_and_watchdog time_base_and_watchdog_props u_props (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .power_on_i(power_on_i),
  .sub_osc_clk_i(sub_osc_clk_i), .main_osc_clk_i(main_osc_clk_i), .stop_i(stop_i),
  .req_i(req_i), .rdata_o(rdata_o), .tick_irq_o(tick_irq_o), .stop_wake_o(stop_wake_o),
  .wdog_reset_o(wdog_reset_o), .periph_run_o(periph_run_o), .misc_ctrl_o(misc_ctrl_o),
  .other_unit_sel_o(other_unit_sel_o)
);

// ===== time_base_and_watchdog_test.sv
// self-checking bench for the time base and watchdog block
// assumes both oscillator pins toggle together, one rising edge every four clocks
`timescale 1ns/1ps
module time_base_and_watchdog_test
  import tick_wdog_pkg::*;
;
  logic clk_i, rst_n_i, power_on_i, sub_osc_clk_i, main_osc_clk_i, stop_i;
  reg_req_t req_i;
  logic [7:0] rdata_o, x;
  logic [3:0] other_unit_sel_o;
  logic tick_irq_o, stop_wake_o, wdog_reset_o, periph_run_o;
  misc_ctrl_t misc_ctrl_o;
  int fail_count, n_compared, cnt, wd_seen;

  time_base_and_watchdog dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .power_on_i(power_on_i),
    .sub_osc_clk_i(sub_osc_clk_i), .main_osc_clk_i(main_osc_clk_i), .stop_i(stop_i),
    .req_i(req_i), .rdata_o(rdata_o), .tick_irq_o(tick_irq_o), .stop_wake_o(stop_wake_o),
    .wdog_reset_o(wdog_reset_o), .periph_run_o(periph_run_o), .misc_ctrl_o(misc_ctrl_o),
    .other_unit_sel_o(other_unit_sel_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req_i <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    req_i <= '0;
    @(posedge clk_i);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    req_i <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_i);
    req_i <= '0;
    #1 chk(rdata_o, e);
    @(posedge clk_i);
  endtask
  // model: cnt follows the time-base counter, one step per rising pin edge
  task automatic edges(input int n);
    repeat (n) begin
      sub_osc_clk_i <= 1'b1;
      main_osc_clk_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      sub_osc_clk_i <= 1'b0;
      main_osc_clk_i <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
    cnt += n;
  endtask
  task automatic pulse();
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
  endtask
  // stop two edges short of the tap wrap, then step onto it with two edges
  task automatic period(input rate_t r, input int k, input logic en);
    int m, d;
    m = (1 << k) - 1;
    d = m - (cnt & m);
    // too close to the wrap: let that event pass first
    if (d < 2) begin
      edges(d + 1);
      d = m;
    end
    wr(TICK_CONTROL_TWO_ADDR, {1'b0, en, r, 4'h8});
    edges(d - 1);
    rdchk(TICK_CONTROL_TWO_ADDR, {1'b0, en, r, 4'h0});
    edges(2);
    rdchk(TICK_CONTROL_TWO_ADDR, {1'b1, en, r, 4'h0});
    chk(tick_irq_o, en);
    chk(stop_wake_o, en);
    wr(TICK_CONTROL_TWO_ADDR, {1'b0, en, r, 4'h0});
    rdchk(TICK_CONTROL_TWO_ADDR, {1'b1, en, r, 4'h0});
  endtask

  always @(posedge clk_i) if (wdog_reset_o === 1'b1) wd_seen++;

  initial begin
    repeat (95000) @(posedge clk_i);
    fail_count++;
    tally_and_finish();
  end

  initial begin
    rst_n_i = 1'b0;
    power_on_i = 1'b1;
    sub_osc_clk_i = 1'b0;
    main_osc_clk_i = 1'b0;
    stop_i = 1'b0;
    req_i = '0;
    fail_count = 0;
    n_compared = 0;
    wd_seen = 0;
    cnt = 'h78;
    void'($urandom(32'h5cdb));
    repeat (12) @(posedge clk_i);
    power_on_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rdchk(TICK_CONTROL_ONE_ADDR, 8'h00);
    rdchk(TICK_CONTROL_TWO_ADDR, 8'h30);
    rdchk(MISC_CLOCK_STATUS_ADDR, 8'h02);
    rdchk(8'h20, 8'h00);
    x = 8'($urandom);
    wr(TICK_CONTROL_ONE_ADDR, {4'h7, x[3:0]});
    wr(TICK_CONTROL_ONE_ADDR, {4'h8, x[7:4]});
    rdchk(TICK_CONTROL_ONE_ADDR, {4'h0, x[7:4]});
    chk(other_unit_sel_o, x[7:4]);
    period(RATE_DIV128, 7, 1'b1);
    period(RATE_DIV4096, 12, 1'b0);
    rdchk(MISC_CLOCK_STATUS_ADDR, 8'h02);
    period(RATE_DIV8192, 13, 1'b1);
    rdchk(MISC_CLOCK_STATUS_ADDR, 8'hc2);
    pulse();
    rdchk(TICK_CONTROL_TWO_ADDR, 8'h30);
    rdchk(MISC_CLOCK_STATUS_ADDR, 8'hc2);
    period(RATE_DIV16384, 14, 1'b1);
    pulse();
    wr(TICK_CONTROL_TWO_ADDR, 8'h0b);
    rdchk(TICK_CONTROL_TWO_ADDR, 8'h02);
    edges(127 - (cnt & 127) + 64);
    wr(TICK_CONTROL_TWO_ADDR, 8'h01);
    rdchk(TICK_CONTROL_TWO_ADDR, 8'h82);
    repeat (5) begin
      edges(128);
      wr(TICK_CONTROL_TWO_ADDR, 8'h09);
    end
    stop_i <= 1'b1;
    edges(384);
    chk(8'(wd_seen), 8'h00);
    rdchk(TICK_CONTROL_TWO_ADDR, 8'h82);
    stop_i <= 1'b0;
    edges(128);
    chk(8'(wd_seen), 8'h01);
    rdchk(TICK_CONTROL_TWO_ADDR, 8'h80);
    pulse();
    // park time base and prescaler at 127; stop lag is a multiple of 128
    edges(127 - (cnt & 127));
    x = 8'($urandom);
    wr(TICK_CONTROL_ONE_ADDR, {4'hf, x[3:0]});
    wr(TICK_CONTROL_ONE_ADDR, {4'h0, x[7:4]});
    rdchk(TICK_CONTROL_ONE_ADDR, {4'h8, x[7:4]});
    wr(TICK_CONTROL_TWO_ADDR, 8'h48);
    stop_i <= 1'b1;
    edges(1);
    rdchk(TICK_CONTROL_TWO_ADDR, 8'h40);
    stop_i <= 1'b0;
    edges(1);
    rdchk(TICK_CONTROL_TWO_ADDR, 8'hc0);
    chk(tick_irq_o, 8'h01);
    chk(stop_wake_o, 8'h00);
    wr(MISC_CLOCK_STATUS_ADDR, {4'hf, x[3:2], 1'b1, x[0]});
    rdchk(MISC_CLOCK_STATUS_ADDR, {4'hc, x[3:2], 1'b1, x[0]});
    chk(misc_ctrl_o, {4'h0, x[3:2], 1'b1, x[0]});
    wr(MISC_CLOCK_STATUS_ADDR, {4'h0, x[3:2], 1'b0, x[0]});
    rdchk(MISC_CLOCK_STATUS_ADDR, {4'h4, x[3:2], 1'b0, x[0]});
    stop_i <= 1'b1;
    @(posedge clk_i);
    #1 chk(periph_run_o, 8'h00);
    @(posedge clk_i);
    stop_i <= 1'b0;
    pulse();
    chk(misc_ctrl_o, 8'h02);
    tally_and_finish();
  end
endmodule
